/* File: bench/atc_timer_sva.sv */
// Port-level properties of the eight-bit timer.
`timescale 1ns/1ps
module atc_timer_sva (
    // Clock and reset
    input wire logic       clock,
    input wire logic       reset_n,
    input wire logic       clk_en,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_write,
    // Requests and acknowledges
    input wire logic       irq_overflow,
    input wire logic       irq_compare_a,
    input wire logic       irq_compare_b,
    input wire logic       irq_ack_overflow,
    input wire logic       irq_ack_compare_a,
    // Pin A and range status
    input wire logic       port_data_a,
    input wire logic       port_dir_a,
    input wire logic       wave_out_a,
    input wire logic       wave_oe_n_a,
    input wire logic       at_bottom,
    input wire logic       at_max
);
    // Shadow copies of the control fields, rebuilt from the writes seen.
    logic [1:0] com_q;
    logic [2:0] cs_q;
    logic [2:0] msk_q;
    logic       pwr_q;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            com_q <= 2'h0;
            cs_q  <= 3'h0;
            msk_q <= 3'h0;
            pwr_q <= 1'b1;
        end else if (reg_write && clk_en) begin
            if (reg_addr == 4'h0) com_q <= reg_wdata[7:6];
            if (reg_addr == 4'h1) cs_q <= reg_wdata[2:0];
            if (reg_addr == 4'h6) msk_q <= reg_wdata[2:0];
            if (reg_addr == 4'h8) pwr_q <= reg_wdata[0];
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    property p_oe_dir;
        $past(reset_n) |-> wave_oe_n_a == !$past(port_dir_a);
    endproperty
    a_oe_dir: assert property (p_oe_dir)
        else $error("pin enable does not follow direction");
    property p_port_pass;
        $past(reset_n) && $past(com_q) == 2'h0
            |-> wave_out_a == $past(port_data_a);
    endproperty
    a_port_pass: assert property (p_port_pass)
        else $error("port data not passed with output mode zero");
    property p_irq_mask;
        $past(reset_n) |-> ({irq_compare_b, irq_compare_a, irq_overflow}
            & ~$past(msk_q)) == 3'h0;
    endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("request raised while masked");
    property p_ack_ovf;
        irq_ack_overflow && cs_q == 3'h0 |-> ##2 !irq_overflow;
    endproperty
    a_ack_ovf: assert property (p_ack_ovf)
        else $error("overflow request survives acknowledge");
    property p_ack_cmp;
        irq_ack_compare_a && cs_q == 3'h0 |-> ##2 !irq_compare_a;
    endproperty
    a_ack_cmp: assert property (p_ack_cmp)
        else $error("compare request survives acknowledge");
    property p_stop;
        !reg_write && (cs_q == 3'h0 || pwr_q)
            |=> ##1 $stable(at_bottom) && $stable(at_max);
    endproperty
    a_stop: assert property (p_stop)
        else $error("counter moved while stopped");
    property p_wr_max;
        reg_write && reg_addr == 4'h2 && reg_wdata == 8'hff |-> ##2 at_max;
    endproperty
    a_wr_max: assert property (p_wr_max)
        else $error("max not signalled after write");
    property p_wr_bot;
        reg_write && reg_addr == 4'h2 && reg_wdata == 8'h00
            |-> ##2 at_bottom;
    endproperty
    a_wr_bot: assert property (p_wr_bot)
        else $error("bottom not signalled after write");
    property p_excl;
        !(at_bottom && at_max);
    endproperty
    a_excl: assert property (p_excl)
        else $error("bottom and max together");
    c_ovf: cover property ($rose(irq_overflow));
    c_ack: cover property (irq_ack_compare_a && cs_q == 3'h0);
    c_wrap: cover property (at_max ##1 at_bottom);
endmodule
bind atc_timer atc_timer_sva i_atc_timer_sva (
    .clock, .reset_n, .clk_en, .reg_addr, .reg_wdata, .reg_write,
    .irq_overflow, .irq_compare_a, .irq_compare_b, .irq_ack_overflow,
    .irq_ack_compare_a, .port_data_a, .port_dir_a, .wave_out_a,
    .wave_oe_n_a, .at_bottom, .at_max
);

/* File: bench/tb_atc_timer.sv */
// Self-checking bench for the eight-bit timer.
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
    error_cnt++; $display("CHECK FAILED t=%0t got %h want %h", \
    $time, g, e); end end
module tb_atc_timer;
    logic       clock = 1'b0;
    logic       reset_n = 1'b0;
    logic       clk_en = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_write = 1'b0;
    logic       reg_read = 1'b0;
    logic [7:0] reg_rdata;
    logic       irq_overflow, irq_compare_a, irq_compare_b;
    logic [2:0] ack = 3'h0;
    logic       osc = 1'b0;
    logic [1:0] pdat = 2'h0;
    logic [1:0] pdir = 2'h0;
    logic [1:0] wout, woe;
    logic       at_bottom, at_max;
    logic [7:0] exp_q[$];
    logic [7:0] rd_exp;
    logic       taken = 1'b0;
    int         error_cnt = 0;
    int         check_count = 0;
    int         cycles = 0;
    atc_timer i_atc_timer (.clock, .reset_n, .clk_en, .reg_addr, .reg_wdata,
        .reg_write, .reg_read, .reg_rdata, .irq_overflow, .irq_compare_a,
        .irq_compare_b, .irq_ack_overflow(ack[0]), .irq_ack_compare_a(ack[1]),
        .irq_ack_compare_b(ack[2]), .osc_pin_in(osc), .port_data_a(pdat[0]),
        .port_dir_a(pdir[0]), .port_data_b(pdat[1]), .port_dir_b(pdir[1]),
        .wave_out_a(wout[0]), .wave_oe_n_a(woe[0]), .wave_out_b(wout[1]),
        .wave_oe_n_b(woe[1]), .at_bottom, .at_max);
    always #25 clock = ~clock;
    task automatic give_verdict;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        taken <= reg_read;
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            give_verdict();
        end
    end
    // Read data stand only in the cycle after the strobe, so look mid-cycle.
    always @(negedge clock) begin
        if (taken) begin
            rd_exp = exp_q.pop_front();
            `CHK(reg_rdata, rd_exp)
        end
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
    endtask
    task automatic settle;
        repeat (2) @(posedge clock);
        @(negedge clock);
    endtask
    initial begin
        logic [7:0] v, m, fl, c;
        int n;
        void'($urandom(44506));
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            rd(i == 9 ? 4'hf : 4'(i), {7'h0, i == 8});
        end
        wr(1, 8'h01);
        wr(2, 8'h05);
        repeat (6) @(posedge clock);
        rd(2, 8'h05);
        wr(8, 8'h00);
        wr(1, 8'h00);
        wr(2, 8'h10);
        repeat (6) @(posedge clock);
        rd(2, 8'h10);
        wr(3, 8'h00);
        wr(4, 8'h02);
        for (int k = 0; k < 12; k++) begin
            v = 8'($urandom_range(0, 15)) - 8'd10;
            n = $urandom_range(0, 9);
            m = 8'($urandom_range(0, 7));
            pdat <= 2'($urandom);
            pdir <= 2'($urandom);
            // The tick right after the counter write never matches.
            fl = 8'h00;
            for (int t = 1; t <= n + 2; t++) begin
                c = v + 8'(t - 1);
                if (c == 8'hff) fl[0] = 1'b1;
                if (t > 1 && c == 8'h00) fl[1] = 1'b1;
                if (t > 1 && c == 8'h02) fl[2] = 1'b1;
            end
            wr(5, 8'h07);
            wr(6, m);
            wr(2, v);
            wr(1, 8'h01);
            repeat (n) @(posedge clock);
            wr(1, 8'h00);
            rd(2, v + 8'(n + 2));
            rd(5, fl);
            @(negedge clock);
            `CHK({irq_compare_b, irq_compare_a, irq_overflow}, fl & m)
            `CHK(wout, pdat)
            `CHK(woe, ~pdir)
            @(posedge clock);
            ack <= 3'h7;
            @(posedge clock);
            ack <= 3'h0;
            rd(5, 8'h00);
        end
        for (int j = 0; j < 2; j++) begin
            v = (j != 0) ? 8'hff : 8'h00;
            wr(1, 8'h01);
            wr(2, v);
            wr(1, 8'h00);
            rd(2, v + 8'h02);
        end
        wr(5, 8'h07);
        wr(0, 8'h42);
        wr(3, 8'h03);
        wr(2, 8'h00);
        wr(1, 8'h01);
        repeat (5) @(posedge clock);
        wr(1, 8'h00);
        rd(2, 8'h03);
        settle();
        `CHK(wout[0], 1'b1)
        wr(5, 8'h07);
        wr(1, 8'h80);
        settle();
        `CHK(wout[0], 1'b0)
        rd(5, 8'h00);
        rd(2, 8'h03);
        wr(1, 8'h80);
        wr(0, 8'h40);
        settle();
        `CHK(wout[0], 1'b1)
        wr(0, 8'h00);
        settle();
        `CHK(wout[0], pdat[0])
        wr(0, 8'h03);
        wr(2, 8'h10);
        wr(4, 8'h20);
        rd(4, 8'h20);
        wr(5, 8'h07);
        wr(1, 8'h01);
        repeat (19) @(posedge clock);
        wr(1, 8'h00);
        rd(5, 8'h00);
        wr(1, 8'h01);
        repeat (254) @(posedge clock);
        wr(1, 8'h00);
        rd(2, 8'h25);
        rd(5, 8'h07);
        // Clock enable low freezes the running counter.
        wr(1, 8'h01);
        clk_en <= 1'b0;
        repeat (10) @(posedge clock);
        clk_en <= 1'b1;
        wr(1, 8'h00);
        rd(2, 8'h27);
        wr(2, 8'h00);
        wr(7, 8'h20);
        wr(1, 8'h01);
        repeat (20) @(posedge clock);
        for (int i = 0; i < 5; i++) begin
            repeat (4) @(posedge clock);
            osc <= 1'b1;
            repeat (4) @(posedge clock);
            osc <= 1'b0;
        end
        repeat (6) @(posedge clock);
        wr(1, 8'h00);
        rd(2, 8'h05);
        repeat (3) @(posedge clock);
        give_verdict();
    end
endmodule

/* File: hdl/atc_consts.svh */
// Register offsets, field positions, reset values and prescaler taps.
`ifndef ATC_CONSTS_SVH
`define ATC_CONSTS_SVH

`define ATC_OFS_CTRL_A     4'h0
`define ATC_OFS_CTRL_B     4'h1
`define ATC_OFS_COUNT      4'h2
`define ATC_OFS_CMP_A      4'h3
`define ATC_OFS_CMP_B      4'h4
`define ATC_OFS_FLAGS      4'h5
`define ATC_OFS_MASK       4'h6
`define ATC_OFS_ASYNC      4'h7
`define ATC_OFS_POWER      4'h8

`define ATC_CA_COM_A_HI    7
`define ATC_CA_COM_A_LO    6
`define ATC_CA_COM_B_HI    5
`define ATC_CA_COM_B_LO    4
`define ATC_CA_WGM_HI      1
`define ATC_CA_WGM_LO      0
`define ATC_CB_FORCE_A     7
`define ATC_CB_FORCE_B     6
`define ATC_CB_WGM2        3
`define ATC_CB_CS_HI       2
`define ATC_CB_CS_LO       0
`define ATC_FL_CMP_B       2
`define ATC_FL_CMP_A       1
`define ATC_FL_OVF         0
`define ATC_AS_CLK_SEL     5
`define ATC_PW_REDUCE      0

`define ATC_BOTTOM         8'h00
`define ATC_MAX            8'hff
`define ATC_RST_BYTE       8'h00
`define ATC_RST_POWER      1'b1

`define ATC_TAP_1          10'h000
`define ATC_TAP_8          10'h007
`define ATC_TAP_32         10'h01f
`define ATC_TAP_64         10'h03f
`define ATC_TAP_128        10'h07f
`define ATC_TAP_256        10'h0ff
`define ATC_TAP_1024       10'h3ff

`endif

/* File: hdl/atc_pkg.sv */
// Types used by the timer design; the bench does not import them.
package atc_pkg;

    typedef enum logic [2:0] {
        ATC_NORMAL    = 3'h0,
        ATC_PC_MAX    = 3'h1,
        ATC_CTC       = 3'h2,
        ATC_FAST_MAX  = 3'h3,
        ATC_RSVD_4    = 3'h4,
        ATC_PC_CMPA   = 3'h5,
        ATC_RSVD_6    = 3'h6,
        ATC_FAST_CMPA = 3'h7
    } atc_mode_t;

    typedef logic [1:0] atc_com_t;

endpackage

/* File: hdl/atc_timer.sv */
// Eight-bit timer with two compare channels, PWM and oscillator clocking.
//
// Operation
// - Counter zero is bottom, signalled.
// - Counter 255 is max, signalled.
// - Top is max or compare A per mode.
// - Clock from I/O clock or oscillator pin.
// - Clock select zero stops the counter.
// - Counter readable and writable while stopped.
// - Counter write beats clear and count.
// - Mode bits choose clear, up, down.
// - Overflow flag per mode, raises request.
// - Compare match sets flag next tick.
// - Flag cleared by acknowledge or one.
// - One flag register, one mask register.
// - Compare buffered in PWM modes only.
// - Buffer loads at top only.
// - Access hits buffer or active register.
// - Force strobe acts on output only.
// - Counter write blocks next tick's match.
// - Output state kept across mode change.
// - Output mode changes act immediately.
// - Nonzero output mode overrides port data.
// - Timer disabled until power bit cleared.
// - Output mode zero takes no action.
// - Normal mode wraps, overflow at zero.
`timescale 1ns/1ps
`include "atc_consts.svh"

module atc_timer #(
    parameter int PRE_W = 10
) (
    // Clock, reset and clock enable
    input  wire logic       clock,
    input  wire logic       reset_n,
    input  wire logic       clk_en,
    // Register port
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    // Interrupt requests and acknowledges
    output logic            irq_overflow,
    output logic            irq_compare_a,
    output logic            irq_compare_b,
    input  wire logic       irq_ack_overflow,
    input  wire logic       irq_ack_compare_a,
    input  wire logic       irq_ack_compare_b,
    // Oscillator pin
    input  wire logic       osc_pin_in,
    // General port function of the two waveform pins
    input  wire logic       port_data_a,
    input  wire logic       port_dir_a,
    input  wire logic       port_data_b,
    input  wire logic       port_dir_b,
    // Waveform pins
    output logic            wave_out_a,
    output logic            wave_oe_n_a,
    output logic            wave_out_b,
    output logic            wave_oe_n_b,
    // Count range status
    output logic            at_bottom,
    output logic            at_max
);

    // Software-visible and internal state.
    atc_pkg::atc_com_t  com_a_q;
    atc_pkg::atc_com_t  com_b_q;
    logic [2:0]         wgm_q;
    logic [2:0]         cs_q;
    logic               async_sel_q;
    logic               power_reduce_q;
    logic [2:0]         mask_q;
    logic [2:0]         flag_q;
    logic [2:0]         flag_d;
    logic [7:0]         count_q;
    logic               down_q;
    logic [7:0]         ocr_a_q;
    logic [7:0]         ocr_b_q;
    logic [7:0]         buf_a_q;
    logic [7:0]         buf_b_q;
    logic               oc_a_q;
    logic               oc_b_q;
    logic               block_q;
    logic [PRE_W-1:0]   pre_q;
    logic               osc_q;

    // Decoded controls.
    atc_pkg::atc_mode_t mode;
    logic               pwm;
    logic               fast;
    logic               phase;
    logic               ctc;
    logic [7:0]         top;
    logic               at_top;
    logic               src;
    logic [PRE_W-1:0]   tap;
    logic               tick;
    logic               wr;
    logic               wr_ca;
    logic               wr_cb;
    logic               wr_count;
    logic               wr_flags;
    logic               match_a;
    logic               match_b;
    logic               force_a;
    logic               force_b;
    logic               ovf_set;

    assign mode  = atc_pkg::atc_mode_t'(wgm_q);
    assign fast  = (mode == atc_pkg::ATC_FAST_MAX) ||
                   (mode == atc_pkg::ATC_FAST_CMPA);
    assign phase = (mode == atc_pkg::ATC_PC_MAX) ||
                   (mode == atc_pkg::ATC_PC_CMPA);
    assign ctc   = (mode == atc_pkg::ATC_CTC);
    assign pwm   = fast || phase;

    // Compare A sets the top only in the modes that name it.
    assign top = (ctc || mode == atc_pkg::ATC_FAST_CMPA ||
                  mode == atc_pkg::ATC_PC_CMPA) ? ocr_a_q
                                                : `ATC_MAX;
    assign at_top = (count_q == top);

    // Write decode; the timer accepts writes to its registers even while powered down.
    assign wr       = reg_write && clk_en;
    assign wr_ca    = wr && reg_addr == `ATC_OFS_CTRL_A;
    assign wr_cb    = wr && reg_addr == `ATC_OFS_CTRL_B;
    assign wr_count = wr && reg_addr == `ATC_OFS_COUNT;
    assign wr_flags = wr && reg_addr == `ATC_OFS_FLAGS;

    // Force strobes only exist in the non-PWM modes.
    assign force_a = wr_cb && reg_wdata[`ATC_CB_FORCE_A] && !pwm;
    assign force_b = wr_cb && reg_wdata[`ATC_CB_FORCE_B] && !pwm;

    // Clock source: the oscillator pin is edge-detected against the
    // system clock, so it must run below half the system clock rate.
    assign src = async_sel_q ? (osc_pin_in && !osc_q) : 1'b1;

    always_comb begin
        unique case (cs_q)
            3'h1:    tap = `ATC_TAP_1;
            3'h2:    tap = `ATC_TAP_8;
            3'h3:    tap = `ATC_TAP_32;
            3'h4:    tap = `ATC_TAP_64;
            3'h5:    tap = `ATC_TAP_128;
            3'h6:    tap = `ATC_TAP_256;
            3'h7:    tap = `ATC_TAP_1024;
            default: tap = `ATC_TAP_1;
        endcase
    end

    // No tick when the source is deselected or the timer is powered down.
    assign tick = clk_en && src && cs_q != 3'h0 && !power_reduce_q &&
                  ((pre_q & tap) == tap);

    // A write to the counter in the previous tick hides the match.
    assign match_a = tick && !block_q && count_q == ocr_a_q;
    assign match_b = tick && !block_q && count_q == ocr_b_q;

    // Overflow point: count 255 (max) in normal and CTC, top in fast PWM,
    // bottom turn-around in phase correct.
    always_comb begin
        if (!tick) begin
            ovf_set = 1'b0;
        end else if (fast) begin
            ovf_set = at_top;
        end else if (phase) begin
            ovf_set = down_q && count_q == `ATC_BOTTOM;
        end else begin
            ovf_set = count_q == `ATC_MAX;
        end
    end

    // Flags: a hardware set wins over a clear in the same cycle.
    always_comb begin
        flag_d = flag_q;
        if (wr_flags) begin
            flag_d = flag_d & ~reg_wdata[2:0];
        end
        if (irq_ack_overflow) begin
            flag_d[`ATC_FL_OVF] = 1'b0;
        end
        if (irq_ack_compare_a) begin
            flag_d[`ATC_FL_CMP_A] = 1'b0;
        end
        if (irq_ack_compare_b) begin
            flag_d[`ATC_FL_CMP_B] = 1'b0;
        end
        if (ovf_set) begin
            flag_d[`ATC_FL_OVF] = 1'b1;
        end
        if (match_a) begin
            flag_d[`ATC_FL_CMP_A] = 1'b1;
        end
        if (match_b) begin
            flag_d[`ATC_FL_CMP_B] = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            flag_q        <= 3'h0;
            irq_overflow  <= 1'b0;
            irq_compare_a <= 1'b0;
            irq_compare_b <= 1'b0;
        end else if (clk_en) begin
            flag_q        <= flag_d;
            irq_overflow  <= flag_d[`ATC_FL_OVF] &&
                             mask_q[`ATC_FL_OVF];
            irq_compare_a <= flag_d[`ATC_FL_CMP_A] &&
                             mask_q[`ATC_FL_CMP_A];
            irq_compare_b <= flag_d[`ATC_FL_CMP_B] &&
                             mask_q[`ATC_FL_CMP_B];
        end
    end

    // Control registers. Output mode bits take effect at once.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            com_a_q        <= 2'h0;
            com_b_q        <= 2'h0;
            wgm_q          <= 3'h0;
            cs_q           <= 3'h0;
            async_sel_q    <= 1'b0;
            mask_q         <= 3'h0;
            power_reduce_q <= `ATC_RST_POWER;
        end else if (clk_en) begin
            if (wr_ca) begin
                com_a_q    <= reg_wdata[`ATC_CA_COM_A_HI:`ATC_CA_COM_A_LO];
                com_b_q    <= reg_wdata[`ATC_CA_COM_B_HI:`ATC_CA_COM_B_LO];
                wgm_q[1:0] <= reg_wdata[`ATC_CA_WGM_HI:`ATC_CA_WGM_LO];
            end
            if (wr_cb) begin
                wgm_q[2] <= reg_wdata[`ATC_CB_WGM2];
                cs_q     <= reg_wdata[`ATC_CB_CS_HI:`ATC_CB_CS_LO];
            end
            if (wr && reg_addr == `ATC_OFS_MASK) begin
                mask_q <= reg_wdata[2:0];
            end
            if (wr && reg_addr == `ATC_OFS_ASYNC) begin
                async_sel_q <= reg_wdata[`ATC_AS_CLK_SEL];
            end
            if (wr && reg_addr == `ATC_OFS_POWER) begin
                power_reduce_q <= reg_wdata[`ATC_PW_REDUCE];
            end
        end
    end

    // Free-running prescaler, advanced by each source pulse.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pre_q <= '0;
            osc_q <= 1'b0;
        end else if (clk_en) begin
            osc_q <= osc_pin_in;
            if (src) begin
                pre_q <= pre_q + 1'b1;
            end
        end
    end

    // Counter unit. A software write has priority over every count.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= `ATC_RST_BYTE;
            down_q  <= 1'b0;
        end else if (clk_en) begin
            if (wr_count) begin
                count_q <= reg_wdata;
            end else if (tick) begin
                if (phase) begin
                    if (!down_q && at_top) begin
                        down_q  <= 1'b1;
                        count_q <= count_q - 1'b1;
                    end else if (down_q && count_q == `ATC_BOTTOM) begin
                        down_q  <= 1'b0;
                        count_q <= count_q + 1'b1;
                    end else if (down_q) begin
                        count_q <= count_q - 1'b1;
                    end else begin
                        count_q <= count_q + 1'b1;
                    end
                end else if ((ctc || fast) && at_top) begin
                    count_q <= `ATC_BOTTOM;
                end else begin
                    count_q <= count_q + 1'b1;
                end
            end
            if (!phase) begin
                down_q <= 1'b0;
            end
        end
    end

    // Block any match on the tick that follows a counter write.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            block_q <= 1'b0;
        end else if (clk_en) begin
            if (wr_count) begin
                block_q <= 1'b1;
            end else if (tick) begin
                block_q <= 1'b0;
            end
        end
    end

    // Compare registers. In PWM modes software reaches the buffer and the
    // active value follows it at top; otherwise writes land directly.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ocr_a_q <= `ATC_RST_BYTE;
            ocr_b_q <= `ATC_RST_BYTE;
            buf_a_q <= `ATC_RST_BYTE;
            buf_b_q <= `ATC_RST_BYTE;
        end else if (clk_en) begin
            if (wr && reg_addr == `ATC_OFS_CMP_A) begin
                buf_a_q <= reg_wdata;
                if (!pwm) begin
                    ocr_a_q <= reg_wdata;
                end
            end else if (pwm && tick && at_top) begin
                ocr_a_q <= buf_a_q;
            end
            if (wr && reg_addr == `ATC_OFS_CMP_B) begin
                buf_b_q <= reg_wdata;
                if (!pwm) begin
                    ocr_b_q <= reg_wdata;
                end
            end else if (pwm && tick && at_top) begin
                ocr_b_q <= buf_b_q;
            end
        end
    end

    // Next output state for one channel. Mode zero leaves it alone.
    function automatic logic wave_next(
        input logic              cur,
        input atc_pkg::atc_com_t com,
        input logic              hit,
        input logic              is_a
    );
        logic nxt;
        nxt = cur;
        if (com == 2'h0) begin
            nxt = cur;
        end else if (!pwm) begin
            if (hit) begin
                nxt = (com == 2'h1) ? !cur : com[0];
            end
        end else if (fast) begin
            if (tick && at_top && com[1]) begin
                nxt = !com[0];
            end
            if (hit) begin
                if (com[1]) begin
                    nxt = com[0];
                end else if (is_a && wgm_q[2]) begin
                    nxt = !cur;
                end
            end
        end else begin
            if (hit && com[1]) begin
                nxt = down_q ? !com[0] : com[0];
            end else if (hit && is_a && wgm_q[2]) begin
                nxt = !cur;
            end
        end
        return nxt;
    endfunction

    // Output state is never reloaded on a mode change.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            oc_a_q <= 1'b0;
            oc_b_q <= 1'b0;
        end else if (clk_en) begin
            oc_a_q <= wave_next(oc_a_q, com_a_q,
                                match_a || force_a, 1'b1);
            oc_b_q <= wave_next(oc_b_q, com_b_q,
                                match_b || force_b, 1'b0);
        end
    end

    // Pin mux; direction always belongs to the port.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wave_out_a  <= 1'b0;
            wave_out_b  <= 1'b0;
            wave_oe_n_a <= 1'b1;
            wave_oe_n_b <= 1'b1;
        end else if (clk_en) begin
            wave_out_a  <= (com_a_q != 2'h0) ? oc_a_q : port_data_a;
            wave_out_b  <= (com_b_q != 2'h0) ? oc_b_q : port_data_b;
            wave_oe_n_a <= !port_dir_a;
            wave_oe_n_b <= !port_dir_b;
        end
    end

    // Range status, registered from the current counter value, one cycle late.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            at_bottom <= 1'b0;
            at_max    <= 1'b0;
        end else if (clk_en) begin
            at_bottom <= count_q == `ATC_BOTTOM;
            at_max    <= count_q == `ATC_MAX;
        end
    end

    // Read data one cycle after the strobe; unmapped reads give zero.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            reg_rdata <= 8'h00;
            if (reg_read) begin
                unique case (reg_addr)
                    `ATC_OFS_CTRL_A: reg_rdata <= {com_a_q, com_b_q,
                                                   2'h0, wgm_q[1:0]};
                    `ATC_OFS_CTRL_B: reg_rdata <= {4'h0, wgm_q[2], cs_q};
                    `ATC_OFS_COUNT:  reg_rdata <= count_q;
                    `ATC_OFS_CMP_A:  reg_rdata <= pwm ? buf_a_q
                                                      : ocr_a_q;
                    `ATC_OFS_CMP_B:  reg_rdata <= pwm ? buf_b_q
                                                      : ocr_b_q;
                    `ATC_OFS_FLAGS:  reg_rdata <= {5'h00, flag_q};
                    `ATC_OFS_MASK:   reg_rdata <= {5'h00, mask_q};
                    `ATC_OFS_ASYNC:  reg_rdata <= {2'h0, async_sel_q,
                                                   5'h00};
                    `ATC_OFS_POWER:  reg_rdata <= {7'h00, power_reduce_q};
                    default:         reg_rdata <= 8'h00;
                endcase
            end
        end
    end

endmodule
